// ==== rtl/clk_gate_cell.sv ====
// Glitch-free gate for one secondary clock output
`timescale 1ns/100ps
module clk_gate_cell (
  input wire logic clkIn,
  input wire logic rstn,
  input wire logic enable,
  output logic clkOut
);
  logic enMeta_q;
  logic enSync_q;

  // Enable comes from the system clock domain: two falling-edge stages settle it,
  // and the gate only changes while the clock is low
  always_ff @(negedge clkIn or negedge rstn) begin
    if (!rstn) begin
      enMeta_q <= 1'b0;
      enSync_q <= 1'b0;
    end else begin
      enMeta_q <= enable;
      enSync_q <= enMeta_q;
    end
  end

  assign clkOut = clkIn & enSync_q;
endmodule : clk_gate_cell

// ==== rtl/sec_clk_pkg.sv ====
// Constants for the secondary clock and power control block
package sec_clk_pkg;
  // Configuration byte offsets
  localparam logic [7:0] GEN_CTRL_OFFSET = 8'hD4;
  localparam logic [7:0] CLK_DISABLE_OFFSET = 8'hD8;
  localparam logic [7:0] CLK_MASK_OFFSET = 8'hD9;
  // Field positions in the general control register
  localparam int VC_FLAG_BIT = 12;
  localparam int D3_STOP_BIT = 11;
  localparam int WAKE_METHOD_BIT = 10;
  localparam int SCALE_LSB = 8;
  localparam int VALUE_LSB = 0;
  localparam int OVRD_LSB = 20;
  // Reset values
  localparam logic [1:0] SCALE_RESET = 2'h2;
  localparam logic [7:0] VALUE_RESET = 8'h5F;
  localparam logic [6:0] CLK_DISABLE_RESET = 7'h00;
  localparam logic [6:0] CLK_MASK_RESET = 7'h00;
  localparam logic [2:0] OVRD_RESET = 3'h0;
  // Power override codes that gate masked clocks
  localparam logic [2:0] OVRD_CLK_GATE = 3'h2;
  localparam logic [2:0] OVRD_CLK_GATE_PIN = 3'h3;
  // Number of secondary clock outputs
  localparam int NUM_CLKS = 7;
  // Power states
  typedef enum logic [1:0] {PS_D0 = 2'b00, PS_D1 = 2'b01, PS_D2 = 2'b11, PS_D3 = 2'b10} power_state_t;
endpackage : sec_clk_pkg

// ==== rtl/secondary_clock_power_control.sv ====
// Secondary clock disable, D3 clock stop, wake method and minimum power fields
`timescale 1ns/100ps
module secondary_clock_power_control
  import sec_clk_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic auxPorRstn,
  input wire logic cfgWrEn,
  input wire logic cfgRdEn,
  input wire logic [7:0] cfgAddr,
  input wire logic [3:0] cfgByteEn,
  input wire logic [31:0] cfgWrData,
  output logic [31:0] cfgRdData,
  input wire logic [1:0] powerStateIn,
  input wire logic slotLimitExceededPin,
  input wire logic l2WakeRequest,
  input wire logic pciClkIn,
  output logic wakeSidebandReq,
  output logic beaconReq,
  output logic [6:0] secClkPins,
  output logic secClkStopped
);
  // ==================================================
  // Register storage
  logic d3StopEnable_q;
  logic wakeMethod_q;
  logic [1:0] minPowerScale_q;
  logic [7:0] minPowerValue_q;
  logic [6:0] clkDisable_q;
  logic [6:0] clkMask_q;
  logic [2:0] powerOverride_q;
  logic limitMeta_q;
  logic limitSync_q;
  logic [31:0] rdData_d;
  logic [31:0] genWord;
  logic [31:0] clkWord;
  logic [NUM_CLKS-1:0] maskGate;
  logic [NUM_CLKS-1:0] clkEnable_d;
  logic [NUM_CLKS-1:0] clkEnable_q;
  logic inD3;
  logic d3ClockStop;
  logic ovrdGate;
  logic genHit;
  logic clkHit;
  logic genWrite;
  logic clkWrite;

  // ==================================================
  // Address decode and write strobes
  // Only two dwords are mapped; every other offset reads zero and drops writes
  assign genHit = (cfgAddr == GEN_CTRL_OFFSET);
  assign clkHit = (cfgAddr == CLK_DISABLE_OFFSET);
  // Write strobes, qualified by the lane enables inside each process
  assign genWrite = cfgWrEn && genHit;
  assign clkWrite = cfgWrEn && clkHit;

  // ==================================================
  // Sticky bits, cleared only by the auxiliary power-on reset
  // A link or global reset leaves them alone so the wake setup survives L2
  // Sticky power bits
  always_ff @(posedge sys_clk or negedge auxPorRstn) begin
    if (!auxPorRstn) begin
      d3StopEnable_q <= 1'b0;
      wakeMethod_q <= 1'b0;
    end else if (genWrite && cfgByteEn[1]) begin
      d3StopEnable_q <= cfgWrData[D3_STOP_BIT];
      wakeMethod_q <= cfgWrData[WAKE_METHOD_BIT];
    end
  end

  // Minimum power fields, writable by software or a loader
  // Default on rstn, not on the auxiliary power-on reset
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      minPowerScale_q <= SCALE_RESET;
      minPowerValue_q <= VALUE_RESET;
    end else if (genWrite) begin
      if (cfgByteEn[1]) begin
        minPowerScale_q <= cfgWrData[SCALE_LSB+:2];
      end
      if (cfgByteEn[0]) begin
        minPowerValue_q <= cfgWrData[VALUE_LSB+:8];
      end
    end
  end

  // Power override field in the third general control byte (lane 2)
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      powerOverride_q <= OVRD_RESET;
    end else if (genWrite && cfgByteEn[2]) begin
      powerOverride_q <= cfgWrData[OVRD_LSB+:3];
    end
  end

  // Clock disable byte in lane 0, mask byte in lane 1 of the D8h word
  // Disable bits, bit 7 dropped
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      clkDisable_q <= CLK_DISABLE_RESET;
      clkMask_q <= CLK_MASK_RESET;
    end else if (clkWrite) begin
      if (cfgByteEn[0]) begin
        clkDisable_q <= cfgWrData[6:0];
      end
      if (cfgByteEn[1]) begin
        clkMask_q <= cfgWrData[14:8];
      end
    end
  end

  // Power limit pin synchroniser
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      limitMeta_q <= 1'b0;
      limitSync_q <= 1'b0;
    end else begin
      limitMeta_q <= slotLimitExceededPin;
      limitSync_q <= limitMeta_q;
    end
  end

  // ==================================================
  // Read path
  // General control dword; the structure flag and all unlisted bits stay low
  always_comb begin
    genWord = 32'h0000_0000;
    genWord[VC_FLAG_BIT] = 1'b0;
    genWord[D3_STOP_BIT] = d3StopEnable_q;
    genWord[WAKE_METHOD_BIT] = wakeMethod_q;
    genWord[SCALE_LSB+:2] = minPowerScale_q;
    genWord[VALUE_LSB+:8] = minPowerValue_q;
    genWord[OVRD_LSB+:3] = powerOverride_q;
  end

  // Clock dword: disable byte, mask byte and the stopped status bit
  always_comb begin
    clkWord = 32'h0000_0000;
    clkWord[6:0] = clkDisable_q;
    clkWord[14:8] = clkMask_q;
    clkWord[16] = secClkStopped;
  end

  // Select the addressed dword; unmapped offsets return zero
  always_comb begin
    rdData_d = 32'h0000_0000;
    if (genHit) begin
      rdData_d = genWord;
    end else if (clkHit) begin
      rdData_d = clkWord;
    end
  end

  // Read data is registered and holds until the next read strobe
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cfgRdData <= 32'h0000_0000;
    end else if (cfgRdEn) begin
      cfgRdData <= rdData_d;
    end
  end

  // ==================================================
  // Clock enables and gating
  assign inD3 = (power_state_t'(powerStateIn) == PS_D3);
  // D3 stop only when software allowed it
  assign d3ClockStop = inD3 && d3StopEnable_q;
  assign ovrdGate = limitSync_q && ((powerOverride_q == OVRD_CLK_GATE) || (powerOverride_q == OVRD_CLK_GATE_PIN));

  // Per output enable terms and gate cells
  genvar g;
  generate
    for (g = 0; g < NUM_CLKS; g++) begin : gClk
      // Mask acts only while the override gate is active
      assign maskGate[g] = ovrdGate && clkMask_q[g];
      assign clkEnable_d[g] = !clkDisable_q[g] && !maskGate[g] && !d3ClockStop;
      // Glitch-free gate in the source clock domain
      clk_gate_cell uGate (
        .clkIn(pciClkIn),
        .rstn(rstn),
        .enable(clkEnable_q[g]),
        .clkOut(secClkPins[g])
      );
    end
  endgenerate

  // Enables leave this domain from flip-flops, so the gate synchronisers never see a decode glitch
  // Registered enables
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      clkEnable_q <= ~CLK_DISABLE_RESET;
    end else begin
      clkEnable_q <= clkEnable_d;
    end
  end

  // Status bit: every output is held off
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      secClkStopped <= 1'b0;
    end else begin
      secClkStopped <= (clkEnable_q == 7'h00);
    end
  end

  // Wake signalling for L2 exit; the sideband request is always raised
  // Wake method select
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wakeSidebandReq <= 1'b0;
      beaconReq <= 1'b0;
    end else begin
      wakeSidebandReq <= l2WakeRequest;
      beaconReq <= l2WakeRequest && wakeMethod_q;
    end
  end
endmodule : secondary_clock_power_control

// ==== verif/sec_clk_load.sv ====
// Clock load model for the secondary bus
`timescale 1ns/100ps
module sec_clk_load (
  input wire logic [6:0] secClkPins,
  input wire logic clr,
  output logic [6:0] ran
);
  for (genvar i = 0; i < 7; i++) begin : g_load
    always @(posedge secClkPins[i] or posedge clr) ran[i] <= !clr;
  end
endmodule : sec_clk_load

// ==== verif/sec_clk_monitor.sv ====
// Assertion checker for the clock power control ports
`timescale 1ns/100ps
module sec_clk_monitor
  import sec_clk_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic cfgWrEn,
  input wire logic cfgRdEn,
  input wire logic [7:0] cfgAddr,
  input wire logic [3:0] cfgByteEn,
  input wire logic [31:0] cfgWrData,
  input wire logic [31:0] cfgRdData,
  input wire logic l2WakeRequest,
  input wire logic wakeSidebandReq,
  input wire logic beaconReq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Reads of the two mapped dwords
  wire rdG = cfgRdEn && cfgAddr == GEN_CTRL_OFFSET;
  wire rdC = cfgRdEn && cfgAddr == CLK_DISABLE_OFFSET;
  property p_vc; rdG |=> !cfgRdData[VC_FLAG_BIT]; endproperty
  a_vc: assert property (p_vc) else $error("flag set");
  property p_rsv; rdC |=> !cfgRdData[7]; endproperty
  a_rsv: assert property (p_rsv) else $error("bit 7 set");
  property p_map; cfgRdEn && !rdG && !rdC |=> cfgRdData == 32'h0000_0000; endproperty
  a_map: assert property (p_map) else $error("unmapped read");
  property p_hold; !cfgRdEn |=> $stable(cfgRdData); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_wake; l2WakeRequest |=> wakeSidebandReq; endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_bcn; beaconReq |-> $past(l2WakeRequest); endproperty
  a_bcn: assert property (p_bcn) else $error("stray beacon");
  property p_grb; cfgWrEn && cfgAddr == GEN_CTRL_OFFSET && &cfgByteEn ##1 rdG
    |=> cfgRdData[11:0] == $past(cfgWrData[11:0], 2); endproperty
  a_grb: assert property (p_grb) else $error("control readback");
  property p_crb; cfgWrEn && cfgAddr == CLK_DISABLE_OFFSET && cfgByteEn[0] ##1 rdC
    |=> cfgRdData[6:0] == $past(cfgWrData[6:0], 2); endproperty
  a_crb: assert property (p_crb) else $error("disable readback");
endmodule : sec_clk_monitor
bind secondary_clock_power_control sec_clk_monitor u_mon (.*);

// ==== verif/tb_secondary_clock_power_control.sv ====
// Self-checking bench for the clock power control block
`timescale 1ns/100ps
`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_secondary_clock_power_control
  import sec_clk_pkg::*;
;
  typedef struct {logic [7:0] a; logic [3:0] be; logic [31:0] d; logic [31:0] e;} row_t;
  logic sys_clk, rstn, auxPorRstn, cfgWrEn, cfgRdEn, slotLimitExceededPin, l2WakeRequest, pciClkIn, clr;
  logic wakeSidebandReq, beaconReq, secClkStopped;
  logic [7:0] cfgAddr;
  logic [3:0] cfgByteEn;
  logic [31:0] cfgWrData, cfgRdData;
  logic [1:0] powerStateIn;
  logic [6:0] secClkPins, ran;
  int mismatches, nChecks;
  row_t rows[4] = '{'{8'hD4, 4'hF, 32'h0000_1F23, 32'h0000_0F23},
    '{8'hD4, 4'h1, 32'h0000_0044, 32'h0000_0F44},
    '{8'hD8, 4'h1, 32'h0000_00FF, 32'h0000_007F},
    '{8'hE0, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000}};
  secondary_clock_power_control dut_u (.*);
  sec_clk_load u_load (.*);
  // Two unrelated clocks
  initial begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    pciClkIn = 1'h0;
    forever #15 pciClkIn = ~pciClkIn;
  end
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    {cfgAddr, cfgByteEn, cfgWrData, cfgWrEn} = {a, be, d, 1'h1};
    @(negedge sys_clk);
    cfgWrEn = 1'h0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    {cfgAddr, cfgRdEn} = {a, 1'h1};
    @(negedge sys_clk);
    cfgRdEn = 1'h0;
    `CHK(cfgRdData & 32'hFFFE_FFFF, e)
    @(negedge sys_clk);
  endtask : rdc
  task automatic wake(input logic e);
    l2WakeRequest = 1'h1;
    @(negedge sys_clk);
    l2WakeRequest = 1'h0;
    `CHK({wakeSidebandReq, beaconReq}, {1'h1, e})
  endtask : wake
  task automatic loads(input logic [6:0] e);
    repeat (40) @(negedge sys_clk);
    clr = 1'h1;
    @(negedge sys_clk);
    clr = 1'h0;
    repeat (40) @(negedge sys_clk);
    `CHK(ran, e)
  endtask : loads
  task automatic report_and_stop();
    $display("mismatches %0d checks %0d", mismatches, nChecks);
    if (mismatches == 0 && nChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  // Main sequence
  initial begin
    {rstn, auxPorRstn, cfgWrEn, cfgRdEn, slotLimitExceededPin, l2WakeRequest, clr} = '0;
    {cfgAddr, cfgByteEn, cfgWrData, powerStateIn} = '0;
    repeat (8) @(negedge sys_clk);
    {rstn, auxPorRstn} = 2'h3;
    rdc(GEN_CTRL_OFFSET, 32'({SCALE_RESET, VALUE_RESET}));
    rdc(CLK_DISABLE_OFFSET, 32'h0000_0000);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].be, rows[i].d);
      rdc(rows[i].a, rows[i].e);
    end
    wake(1'h1);
    wr(CLK_DISABLE_OFFSET, 4'h1, 32'h0000_0005);
    loads(7'h7A);
    wr(CLK_DISABLE_OFFSET, 4'h3, 32'h0000_0100);
    slotLimitExceededPin = 1'h1;
    @(negedge sys_clk);
    for (int ov = 3; ov >= 0; ov--) begin
      wr(GEN_CTRL_OFFSET, 4'h4, 32'(ov) << OVRD_LSB);
      loads(ov[1] ? 7'h7E : 7'h7F);
    end
    slotLimitExceededPin = 1'h0;
    wr(GEN_CTRL_OFFSET, 4'h4, 32'(OVRD_CLK_GATE) << OVRD_LSB);
    loads(7'h7F);
    powerStateIn = PS_D3;
    loads(7'h00);
    `CHK(secClkStopped, 1'h1)
    wr(GEN_CTRL_OFFSET, 4'h2, 32'h0000_0200);
    loads(7'h7F);
    `CHK(secClkStopped, 1'h0)
    wake(1'h0);
    powerStateIn = PS_D0;
    wr(GEN_CTRL_OFFSET, 4'h2, 32'h0000_0C00);
    @(negedge sys_clk);
    wr(CLK_DISABLE_OFFSET, 4'h1, 32'h0000_007F);
    rstn = 1'h0;
    repeat (2) @(negedge sys_clk);
    rstn = 1'h1;
    rdc(GEN_CTRL_OFFSET, 32'h0000_0E5F);
    rdc(CLK_DISABLE_OFFSET, 32'h0000_0000);
    wr(GEN_CTRL_OFFSET, 4'h1, 32'h0000_0033);
    rdc(GEN_CTRL_OFFSET, 32'h0000_0E33);
    report_and_stop();
  end
endmodule : tb_secondary_clock_power_control
